/* design/rtca_pkg.sv */
/*
 * Constants and carrier types for the clock alarm and indirect access block.
 * Assumes an 8-bit special function register bus inside the same clock domain.
 */
package rtca_pkg;
   // ****************
   // Register offsets
   // ****************
   localparam logic [7:0] ADDR_CLOCK_CONFIG   = 8'ha1;
   localparam logic [7:0] ADDR_ALARM_ENABLES  = 8'ha2;
   localparam logic [7:0] ADDR_IND_POINTER    = 8'ha3;
   localparam logic [7:0] ADDR_IND_DATA       = 8'ha4;
   localparam logic [7:0] ADDR_UNLOCK_KEY     = 8'hc1;
   localparam logic [7:0] ADDR_NOMINAL_TRIM   = 8'hf6;
   localparam logic [7:0] ADDR_TEMP_TRIM      = 8'hf7;
   // ****************
   // Fields and values
   // ****************
   localparam int         CFG_ALARM_FLAG_BIT  = 6;
   localparam int         CFG_INTV_FLAG_BIT   = 2;
   localparam logic [7:0] CFG_RW_MASK         = 8'h3a;
   localparam int         EN_SEC_BIT          = 0;
   localparam int         EN_MIN_BIT          = 1;
   localparam int         EN_HOUR_BIT         = 2;
   localparam int         EN_WDAY_BIT         = 3;
   localparam int         EN_MDAY_BIT         = 4;
   localparam logic [7:0] EN_MASK             = 8'h1f;
   localparam int         PTR_WSEL_BIT        = 7;
   localparam logic [7:0] PTR_MASK            = 8'h9f;
   localparam logic [7:0] KEY_TIME_UNLOCK     = 8'hea;
   localparam logic [7:0] KEY_POWER_UNLOCK    = 8'ha7;
   localparam logic [7:0] RESET_BYTE          = 8'h00;
   localparam logic [4:0] IDX_ALARM_FIRST     = 5'h0a;
   localparam logic [4:0] IDX_ALARM_LAST      = 5'h0e;
   localparam int         ALARM_SLOTS         = 5;
   // ****************
   // Carriers
   // ****************
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rtca_sfr_req_t;
   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] wday;
      logic [7:0] mday;
   } rtca_time_t;
   typedef struct packed {
      logic       valid;
      logic [4:0] index;
      logic [7:0] data;
   } rtca_tk_wr_t;
endpackage

/* design/rtca_core.sv */
/*
 * Alarm match, indirect pointer/data access, unlock key and trim registers.
 * Assumes the timekeeping counters sit outside, return the byte at the
 * pointer index combinationally, and take one-cycle write pulses.
 */
`timescale 1ns/1ps
`default_nettype none
module rtca_core
   import rtca_pkg::*;
(
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          rst,
   // Register bus
   input  wire rtca_sfr_req_t sfr_req,
   output logic [7:0]         sfr_rdata_q,
   // Timekeeping side
   input  wire rtca_time_t    tk_time,
   input  wire logic [7:0]    tk_rd_data,
   input  wire logic          interval_event,
   output logic [4:0]         tk_index_q,
   output rtca_tk_wr_t        tk_wr_q,
   // Interrupt and unlocks
   input  wire logic          clock_irq_en,
   output logic               clock_irq_q,
   output logic               power_unlock_q,
   output logic               time_unlock_q,
   // Calibration
   output logic [7:0]         nominal_trim_q,
   output logic [7:0]         temperature_trim_q
);
   // ****************
   // Helpers
   // ****************
   function automatic logic is_wr(input rtca_sfr_req_t r, input logic [7:0] a);
      is_wr = r.wr && (r.addr == a);
   endfunction

   function automatic logic is_alarm_idx(input logic [4:0] i);
      is_alarm_idx = (i >= IDX_ALARM_FIRST) && (i <= IDX_ALARM_LAST);
   endfunction

   function automatic logic [2:0] slot(input logic [4:0] i);
      logic [4:0] d;
      d = i - IDX_ALARM_FIRST;
      slot = d[2:0];
   endfunction

   logic [7:0] cfg_q, cfg_d;
   logic [7:0] enables_q;
   logic [7:0] pointer_q;
   logic [7:0] data_q, data_d;
   logic [7:0] key_q, key_d;
   logic [7:0] alarm_q [ALARM_SLOTS];
   logic       rd_pend_q;
   logic       match_q;
   logic       all_match;
   logic       any_en;
   logic       data_wr;
   logic       key_ok;

   // ****************
   // Unlock key
   // ****************
   always_comb begin
      key_d = key_q;
      if (is_wr(sfr_req, ADDR_UNLOCK_KEY)) begin
         key_d = sfr_req.wdata;
      end else if (sfr_req.wr) begin
         key_d = RESET_BYTE;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         key_q          <= RESET_BYTE;
         power_unlock_q <= 1'b0;
         time_unlock_q  <= 1'b0;
      end else begin
         key_q          <= key_d;
         power_unlock_q <= (key_d == KEY_POWER_UNLOCK);
         time_unlock_q  <= (key_d == KEY_TIME_UNLOCK);
      end
   end

   assign key_ok  = (key_q == KEY_TIME_UNLOCK);
   assign data_wr = is_wr(sfr_req, ADDR_IND_DATA);

   // ****************
   // Plain registers
   // ****************
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         enables_q          <= RESET_BYTE;
         pointer_q          <= RESET_BYTE;
         nominal_trim_q     <= RESET_BYTE;
         temperature_trim_q <= RESET_BYTE;
      end else begin
         if (is_wr(sfr_req, ADDR_ALARM_ENABLES)) begin
            enables_q <= sfr_req.wdata & EN_MASK;
         end
         if (is_wr(sfr_req, ADDR_IND_POINTER)) begin
            pointer_q <= sfr_req.wdata & PTR_MASK;
         end
         if (is_wr(sfr_req, ADDR_NOMINAL_TRIM)) begin
            nominal_trim_q <= sfr_req.wdata;
         end
         if (is_wr(sfr_req, ADDR_TEMP_TRIM)) begin
            temperature_trim_q <= sfr_req.wdata;
         end
      end
   end

   always_comb tk_index_q = pointer_q[4:0];

   // ****************
   // Indirect access
   // ****************
   always_comb begin
      data_d = data_q;
      if (data_wr) begin
         data_d = sfr_req.wdata;
      end else if (rd_pend_q) begin
         data_d = is_alarm_idx(pointer_q[4:0]) ? alarm_q[slot(pointer_q[4:0])]
                                              : tk_rd_data;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         data_q    <= RESET_BYTE;
         rd_pend_q <= 1'b0;
      end else begin
         data_q    <= data_d;
         rd_pend_q <= is_wr(sfr_req, ADDR_IND_POINTER) && !sfr_req.wdata[PTR_WSEL_BIT];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tk_wr_q <= '0;
      end else begin
         tk_wr_q.valid <= data_wr && pointer_q[PTR_WSEL_BIT] && key_ok
                          && !is_alarm_idx(pointer_q[4:0]);
         tk_wr_q.index <= pointer_q[4:0];
         tk_wr_q.data  <= sfr_req.wdata;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < ALARM_SLOTS; i++) begin
            alarm_q[i] <= RESET_BYTE;
         end
      end else if (data_wr && pointer_q[PTR_WSEL_BIT] && key_ok
                   && is_alarm_idx(pointer_q[4:0])) begin
         alarm_q[slot(pointer_q[4:0])] <= sfr_req.wdata;
      end
   end

   // ****************
   // Alarm match
   // ****************
   always_comb begin
      any_en    = |enables_q[EN_MDAY_BIT:EN_SEC_BIT];
      all_match = any_en
         && (!enables_q[EN_MDAY_BIT] || alarm_q[4] == tk_time.mday)
         && (!enables_q[EN_WDAY_BIT] || alarm_q[3] == tk_time.wday)
         && (!enables_q[EN_HOUR_BIT] || alarm_q[2] == tk_time.hour)
         && (!enables_q[EN_MIN_BIT]  || alarm_q[1] == tk_time.min)
         && (!enables_q[EN_SEC_BIT]  || alarm_q[0] == tk_time.sec);
   end

   // Set wins over a clear in the same cycle
   always_comb begin
      cfg_d = cfg_q;
      if (is_wr(sfr_req, ADDR_CLOCK_CONFIG)) begin
         cfg_d = sfr_req.wdata & (CFG_RW_MASK | (8'h01 << CFG_ALARM_FLAG_BIT)
                                 | (8'h01 << CFG_INTV_FLAG_BIT)) & (cfg_q | CFG_RW_MASK);
      end
      if (all_match && !match_q) begin
         cfg_d[CFG_ALARM_FLAG_BIT] = 1'b1;
      end
      if (interval_event) begin
         cfg_d[CFG_INTV_FLAG_BIT] = 1'b1;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cfg_q       <= RESET_BYTE;
         match_q     <= 1'b0;
         clock_irq_q <= 1'b0;
      end else begin
         cfg_q       <= cfg_d;
         match_q     <= all_match;
         clock_irq_q <= cfg_q[CFG_ALARM_FLAG_BIT] && clock_irq_en;
      end
   end

   // ****************
   // Read back
   // ****************
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sfr_rdata_q <= RESET_BYTE;
      end else begin
         unique case (sfr_req.addr)
            ADDR_CLOCK_CONFIG:  sfr_rdata_q <= cfg_q;
            ADDR_ALARM_ENABLES: sfr_rdata_q <= enables_q;
            ADDR_IND_POINTER:   sfr_rdata_q <= pointer_q;
            ADDR_IND_DATA:      sfr_rdata_q <= data_q;
            ADDR_UNLOCK_KEY:    sfr_rdata_q <= key_q;
            ADDR_NOMINAL_TRIM:  sfr_rdata_q <= nominal_trim_q;
            ADDR_TEMP_TRIM:     sfr_rdata_q <= temperature_trim_q;
            default:            sfr_rdata_q <= RESET_BYTE;
         endcase
      end
   end

   // ****************
   // Checks
   // ****************
   sequence s_key_then_write;
      is_wr(sfr_req, ADDR_UNLOCK_KEY) && sfr_req.wdata == KEY_TIME_UNLOCK
      ##1 data_wr && pointer_q[PTR_WSEL_BIT] && !is_alarm_idx(pointer_q[4:0]);
   endsequence

   AST_MDAY_MISMATCH_BLOCKS: assert property (@(posedge clock) disable iff (rst)
      enables_q[EN_MDAY_BIT] && alarm_q[4] != tk_time.mday |=> !$rose(cfg_q[CFG_ALARM_FLAG_BIT]))
      else $error("Alarm flag rose with month-day mismatch");
   AST_WDAY_MISMATCH_BLOCKS: assert property (@(posedge clock) disable iff (rst)
      enables_q[EN_WDAY_BIT] && alarm_q[3] != tk_time.wday |=> !$rose(cfg_q[CFG_ALARM_FLAG_BIT]))
      else $error("Alarm flag rose with weekday mismatch");
   AST_HOUR_MISMATCH_BLOCKS: assert property (@(posedge clock) disable iff (rst)
      enables_q[EN_HOUR_BIT] && alarm_q[2] != tk_time.hour |=> !$rose(cfg_q[CFG_ALARM_FLAG_BIT]))
      else $error("Alarm flag rose with hour mismatch");
   AST_MIN_MISMATCH_BLOCKS: assert property (@(posedge clock) disable iff (rst)
      enables_q[EN_MIN_BIT] && alarm_q[1] != tk_time.min |=> !$rose(cfg_q[CFG_ALARM_FLAG_BIT]))
      else $error("Alarm flag rose with minute mismatch");
   AST_SEC_MISMATCH_BLOCKS: assert property (@(posedge clock) disable iff (rst)
      enables_q[EN_SEC_BIT] && alarm_q[0] != tk_time.sec |=> !$rose(cfg_q[CFG_ALARM_FLAG_BIT]))
      else $error("Alarm flag rose with second mismatch");
   AST_MATCH_SETS_FLAG: assert property (@(posedge clock) disable iff (rst)
      all_match && !match_q |=> cfg_q[CFG_ALARM_FLAG_BIT])
      else $error("Alarm flag not set on new match");
   AST_IRQ_FOLLOWS_FLAG: assert property (@(posedge clock) disable iff (rst)
      ##1 clock_irq_q == ($past(cfg_q[CFG_ALARM_FLAG_BIT]) && $past(clock_irq_en)))
      else $error("Interrupt does not follow flag and enable");
   AST_READ_LOADS_DATA: assert property (@(posedge clock) disable iff (rst)
      is_wr(sfr_req, ADDR_IND_POINTER) && !sfr_req.wdata[PTR_WSEL_BIT]
      && !is_alarm_idx(sfr_req.wdata[4:0]) ##1 !data_wr |=> data_q == $past(tk_rd_data))
      else $error("Indirect read did not load data");
   AST_KEYED_WRITE_PULSE: assert property (@(posedge clock) disable iff (rst)
      s_key_then_write |=> tk_wr_q.valid ##1 !tk_wr_q.valid)
      else $error("Keyed indirect write not issued once");
   AST_UNKEYED_WRITE_DROPPED: assert property (@(posedge clock) disable iff (rst)
      data_wr && key_q != KEY_TIME_UNLOCK |=> !tk_wr_q.valid)
      else $error("Indirect write passed without key");
   AST_POWER_UNLOCK_ONE_WRITE: assert property (@(posedge clock) disable iff (rst)
      power_unlock_q && sfr_req.wr
      && !(is_wr(sfr_req, ADDR_UNLOCK_KEY) && sfr_req.wdata == KEY_POWER_UNLOCK)
      |=> !power_unlock_q)
      else $error("Power unlock outlived one write");
   AST_FLAG_CLEARS: assert property (@(posedge clock) disable iff (rst)
      is_wr(sfr_req, ADDR_CLOCK_CONFIG) && !sfr_req.wdata[CFG_ALARM_FLAG_BIT]
      && !(all_match && !match_q) |=> !cfg_q[CFG_ALARM_FLAG_BIT])
      else $error("Alarm flag did not clear");

   // Pointer read of an alarm slot, not overridden by a data write
   sequence s_ptr_read_alarm;
      is_wr(sfr_req, ADDR_IND_POINTER) && !sfr_req.wdata[PTR_WSEL_BIT]
      && is_alarm_idx(sfr_req.wdata[4:0]) ##1 !data_wr;
   endsequence

   AST_READ_LOADS_ALARM: assert property (@(posedge clock) disable iff (rst)
      s_ptr_read_alarm |=> data_q == alarm_q[slot($past(pointer_q[4:0]))])
      else $error("Alarm slot read did not load data");
   AST_DATA_WRITE_STORES: assert property (@(posedge clock) disable iff (rst)
      data_wr |=> data_q == $past(sfr_req.wdata))
      else $error("Indirect data write not stored");
   AST_NOMINAL_WRITE_STORES: assert property (@(posedge clock) disable iff (rst)
      is_wr(sfr_req, ADDR_NOMINAL_TRIM) |=> nominal_trim_q == $past(sfr_req.wdata))
      else $error("Nominal trim write not stored");
   AST_TIME_UNLOCK_SET: assert property (@(posedge clock) disable iff (rst)
      is_wr(sfr_req, ADDR_UNLOCK_KEY) && sfr_req.wdata == KEY_TIME_UNLOCK |=> time_unlock_q)
      else $error("Time key did not unlock");
   AST_KEY_ONE_WRITE: assert property (@(posedge clock) disable iff (rst)
      sfr_req.wr && !is_wr(sfr_req, ADDR_UNLOCK_KEY) |=> key_q == RESET_BYTE)
      else $error("Key survived another write");
endmodule
`default_nettype wire

/* bench/rtca_core_bench.sv */
/*
 * Self-checking bench for the clock alarm and indirect access block.
 * Assumes rtca_pkg and rtca_core from design/ are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module rtca_core_bench
   import rtca_pkg::*;
();
   // ****************
   // Stimulus and results
   // ****************
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] rexp;
   } rtca_row_t;
   logic          clock;
   logic          rst;
   logic          interval_event;
   logic          clock_irq_en;
   logic [7:0]    tk_rd_data;
   rtca_sfr_req_t sfr_req;
   rtca_time_t    tk_time;
   logic [7:0]    sfr_rdata_q;
   logic [4:0]    tk_index_q;
   rtca_tk_wr_t   tk_wr_q;
   logic          clock_irq_q;
   logic          power_unlock_q;
   logic          time_unlock_q;
   logic [7:0]    nominal_trim_q;
   logic [7:0]    temperature_trim_q;
   int            bad_count;
   int            num_checks;
   logic [7:0]    al [5] = '{8'h11, 8'h22, 8'h03, 8'h04, 8'h15};
   rtca_row_t     rows [6] = '{'{ADDR_NOMINAL_TRIM, 8'h5a, 8'h5a},
                               '{ADDR_TEMP_TRIM, 8'ha5, 8'ha5},
                               '{ADDR_ALARM_ENABLES, 8'hff, 8'h1f},
                               '{ADDR_UNLOCK_KEY, 8'h3c, 8'h3c},
                               '{8'h55, 8'h77, 8'h00},
                               '{ADDR_IND_POINTER, 8'hff, 8'h9f}};

   rtca_core i_dut (
      .clock              (clock),
      .rst                (rst),
      .sfr_req            (sfr_req),
      .sfr_rdata_q        (sfr_rdata_q),
      .tk_time            (tk_time),
      .tk_rd_data         (tk_rd_data),
      .interval_event     (interval_event),
      .tk_index_q         (tk_index_q),
      .tk_wr_q            (tk_wr_q),
      .clock_irq_en       (clock_irq_en),
      .clock_irq_q        (clock_irq_q),
      .power_unlock_q     (power_unlock_q),
      .time_unlock_q      (time_unlock_q),
      .nominal_trim_q     (nominal_trim_q),
      .temperature_trim_q (temperature_trim_q)
   );

   // ****************
   // Tasks
   // ****************
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_req = '{1'b1, a, d};
      @(posedge clock);
      #2;
   endtask

   task automatic idle(input int n);
      sfr_req.wr = 1'b0;
      repeat (n) begin
         @(posedge clock);
         #2;
      end
   endtask

   task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
      sfr_req.wr = 1'b0;
      sfr_req.addr = a;
      @(posedge clock);
      #2;
      chk(what, 16'(exp), 16'(sfr_rdata_q));
   endtask

   task automatic conclude;
      if (bad_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Only field k matches its alarm value; k of 5 matches none
   function automatic rtca_time_t mk(input int k);
      logic [7:0] f [5];
      for (int j = 0; j < 5; j++) begin
         f[j] = (j == k) ? al[j] : ~al[j];
      end
      return {f[0], f[1], f[2], f[3], f[4]};
   endfunction

   // ****************
   // Clock, sequence and watchdog
   // ****************
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   initial begin
      #100000;
      bad_count++;
      conclude();
   end

   initial begin
      rst = 1'b1;
      sfr_req = '0;
      tk_time = mk(5);
      tk_rd_data = 8'h00;
      interval_event = 1'b0;
      clock_irq_en = 1'b1;
      bad_count = 0;
      num_checks = 0;
      repeat (12) @(posedge clock);
      #2;
      rst = 1'b0;
      chk("trims", 16'h0000, {nominal_trim_q, temperature_trim_q});
      chk("outs", 16'h0000, {12'h000, clock_irq_q, power_unlock_q, time_unlock_q, tk_wr_q.valid});
      rdchk("data reset", ADDR_IND_DATA, 8'h00);
      for (int k = 0; k < 5; k++) begin
         wr(ADDR_IND_POINTER, {3'b000, IDX_ALARM_FIRST + 5'(k)});
         idle(2);
         rdchk("alarm reset", ADDR_IND_DATA, 8'h00);
      end
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         idle(1);
         rdchk("row", rows[i].addr, rows[i].rexp);
      end
      chk("trim outs", 16'h5aa5, {nominal_trim_q, temperature_trim_q});
      tk_rd_data = 8'hc3;
      wr(ADDR_IND_POINTER, 8'h05);
      chk("index", 16'h0005, 16'(tk_index_q));
      idle(2);
      rdchk("ind read", ADDR_IND_DATA, 8'hc3);
      wr(ADDR_IND_POINTER, 8'h83);
      wr(ADDR_UNLOCK_KEY, KEY_TIME_UNLOCK);
      chk("time unlock", 16'h0001, 16'(time_unlock_q));
      wr(ADDR_IND_DATA, 8'h77);
      chk("keyed write", {3'b001, 5'h03, 8'h77}, {2'b00, tk_wr_q});
      chk("key spent", 16'h0000, 16'(time_unlock_q));
      idle(1);
      chk("pulse end", 16'h0000, 16'(tk_wr_q.valid));
      wr(ADDR_IND_POINTER, 8'h84);
      wr(ADDR_UNLOCK_KEY, KEY_TIME_UNLOCK);
      wr(ADDR_ALARM_ENABLES, 8'h00);
      wr(ADDR_IND_DATA, 8'h66);
      chk("stale key", 16'h0000, 16'(tk_wr_q.valid));
      wr(ADDR_UNLOCK_KEY, KEY_POWER_UNLOCK);
      chk("power unlock", 16'h0002, {14'h0, power_unlock_q, time_unlock_q});
      wr(ADDR_NOMINAL_TRIM, 8'h5a);
      chk("power spent", 16'h0000, 16'(power_unlock_q));
      for (int k = 0; k < 5; k++) begin
         wr(ADDR_IND_POINTER, {3'b100, IDX_ALARM_FIRST + 5'(k)});
         wr(ADDR_UNLOCK_KEY, KEY_TIME_UNLOCK);
         wr(ADDR_IND_DATA, al[k]);
         chk("alarm no fwd", 16'h0000, 16'(tk_wr_q.valid));
         idle(1);
         wr(ADDR_IND_POINTER, {3'b000, IDX_ALARM_FIRST + 5'(k)});
         idle(2);
         rdchk("alarm value", ADDR_IND_DATA, al[k]);
      end
      // Each field alone raises the flag; all enabled with one match does not
      for (int k = 0; k < 5; k++) begin
         clock_irq_en = (k != 2);
         tk_time = mk(5);
         wr(ADDR_ALARM_ENABLES, 8'(1 << k));
         idle(1);
         tk_time = mk(k);
         idle(3);
         rdchk("flag set", ADDR_CLOCK_CONFIG, 8'h40);
         chk("irq", 16'(k != 2), 16'(clock_irq_q));
         wr(ADDR_CLOCK_CONFIG, 8'h00);
         tk_time = mk(5);
         wr(ADDR_ALARM_ENABLES, EN_MASK);
         idle(1);
         tk_time = mk(k);
         idle(3);
         rdchk("flag clear", ADDR_CLOCK_CONFIG, 8'h00);
         chk("irq clear", 16'h0000, 16'(clock_irq_q));
      end
      interval_event = 1'b1;
      idle(1);
      interval_event = 1'b0;
      idle(1);
      rdchk("interval flag", ADDR_CLOCK_CONFIG, 8'h04);
      wr(ADDR_NOMINAL_TRIM, 8'h3c);
      rst = 1'b1;
      idle(2);
      rst = 1'b0;
      idle(1);
      chk("trims rerst", 16'h0000, {nominal_trim_q, temperature_trim_q});
      conclude();
   end
endmodule
`default_nettype wire
